// file: common/ppm_defines.vh
// Constants for the shared port pin function multiplexer.
// Assumes inclusion by bare name from the logic files; definitions only.
//
// Summary of operation
// - Input-only peripheral pins always remain usable as general-purpose port bits.
// - Async clock pin is a port bit while the async clock output is off.
// - Async clock output enabled: pin carries async serial clock, still readable as input.
// - Async transmit pin is a port bit while async data output is off.
// - Async data output enabled: pin drives async transmit data, not port data.
// - Sync transmit pin is a port bit while sync data output is off.
// - Sync data output enabled: pin drives sync transmit data, not port data.
// - Sync clock pin is a port bit while sync clock output is off.
// - Sync clock output enabled: pin carries sync clock, still readable as input.
// - Sync receive input always sees its pin level; software sets direction input.
// - Four interrupt pins always feed the interrupt logic; direction set to input.
// - Trigger pin always feeds converter start trigger; direction set to input.
// - Timer event pin always feeds reload timer zero event input.
// - Lower four analog pins are port bits when their analog enable selects port.
// - Upper four analog pins are port bits when their analog enable selects port.
// - Analog pins connect to matching converter channel when analog enable selects converter.
`ifndef PPM_DEFINES_VH
`define PPM_DEFINES_VH

// *****************************************
// Pin map
// *****************************************
`define PPM_NPIN        19
`define PPM_BIT_ACLK    0
`define PPM_BIT_ATX     1
`define PPM_BIT_STX     2
`define PPM_BIT_SCLK    3
`define PPM_BIT_SRX     4
`define PPM_BIT_IRQ0    5
`define PPM_BIT_TRIG    9
`define PPM_BIT_TEVT    10
`define PPM_BIT_ANA0    11
`define PPM_NANA        8

// *****************************************
// Register offsets (byte addresses)
// *****************************************
`define PPM_OFS_DATA    4'h0
`define PPM_OFS_DIR     4'h4
`define PPM_OFS_ANAEN   4'h8
`define PPM_OFS_LEVEL   4'hC

// *****************************************
// Reset values
// *****************************************
`define PPM_RST_DATA    19'h00000
`define PPM_RST_DIR     19'h00000
`define PPM_RST_ANAEN   8'hFF

`endif

// file: logic/ppm_port_pin_function_mux.v
// Shared port pin function multiplexer with an Avalon-MM register slave.
// Assumes pads resolve pin level from padOut/padOe outside; peripheral
// signals arrive on mclk from logic in the same domain.
//
// The placing of the registers and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/100ps
`include "ppm_defines.vh"

module ppm_port_pin_function_mux #(
  parameter NPIN = `PPM_NPIN,
  parameter NANA = `PPM_NANA
) (
  input  wire             mclk,
  input  wire             resetn,
  // Avalon-MM slave
  input  wire [3:0]       avsAddress,
  input  wire             avsRead,
  input  wire             avsWrite,
  input  wire [31:0]      avsWritedata,
  input  wire [3:0]       avsByteenable,
  output reg  [31:0]      avsReaddata,
  output wire             avsWaitrequest,
  // Pads
  input  wire [NPIN-1:0]  padIn,
  output reg  [NPIN-1:0]  padOut,
  output reg  [NPIN-1:0]  padOe,
  // Async serial channel
  input  wire             asyncClkOutEn,
  input  wire             asyncClkOut,
  output wire             asyncClkIn,
  input  wire             asyncTxOutEn,
  input  wire             asyncTxData,
  // Clocked serial interface
  input  wire             syncTxOutEn,
  input  wire             syncTxData,
  input  wire             syncClkOutEn,
  input  wire             syncClkOut,
  output wire             syncClkIn,
  output wire             syncRxData,
  // Input-only peripheral functions
  output wire [3:0]       extIrqUpper,
  output wire             convTrigger,
  output wire             timerEvent,
  // Converter channel connection
  output wire [NANA-1:0]  analogChannelEn
);

  // *****************************************
  // Register bus state
  // *****************************************
  reg  [NPIN-1:0]  portData;
  reg  [NPIN-1:0]  portDir;
  reg  [NANA-1:0]  analogEn;
  reg              busAck;
  wire             busReq;

  // *****************************************
  // Pin input path
  // *****************************************
  reg  [NPIN-1:0]  syncA;
  reg  [NPIN-1:0]  syncB;
  reg  [NPIN-1:0]  syncC;
  reg  [NPIN-1:0]  pinLevel;
  reg  [NPIN-1:0]  gatedLevel;
  wire [NPIN-1:0]  analogMask;
  wire [NPIN-1:0]  stageAgree;

  // *****************************************
  // Output path
  // *****************************************
  wire [NPIN-1:0]  next_padOut;
  wire [NPIN-1:0]  next_padOe;

  genvar g;

  // Byte-lane merge for the writable registers
  function [31:0] mergeBytes;
    input [31:0] oldWord;
    input [31:0] newWord;
    input [3:0]  lanes;
    integer k;
    begin
      mergeBytes = oldWord;
      for (k = 0; k < 4; k = k + 1) begin
        if (lanes[k]) begin
          mergeBytes[k*8 +: 8] = newWord[k*8 +: 8];
        end
      end
    end
  endfunction

  // One-hot placement of a single peripheral signal at its pin index
  function [NPIN-1:0] placeBit;
    input         bitVal;
    input integer pos;
    begin
      placeBit      = {NPIN{1'b0}};
      placeBit[pos] = bitVal;
    end
  endfunction

  // *****************************************
  // Register decode
  // *****************************************
  localparam SEL_NONE  = 3'h0;
  localparam SEL_DATA  = 3'h1;
  localparam SEL_DIR   = 3'h2;
  localparam SEL_ANAEN = 3'h3;
  localparam SEL_LEVEL = 3'h4;

  // Offset decode shared by the merge, write and read paths
  function [2:0] regSelect;
    input [3:0] addr;
    begin
      case (addr)
        `PPM_OFS_DATA:  regSelect = SEL_DATA;
        `PPM_OFS_DIR:   regSelect = SEL_DIR;
        `PPM_OFS_ANAEN: regSelect = SEL_ANAEN;
        `PPM_OFS_LEVEL: regSelect = SEL_LEVEL;
        default:        regSelect = SEL_NONE;
      endcase
    end
  endfunction

  wire [2:0]  regSel;
  wire        wrData;
  wire        wrDir;
  wire        wrAnaEn;
  wire        rdCapture;

  assign regSel    = regSelect(avsAddress);
  // Writes only on the completing edge, so a held request writes again every two cycles
  assign wrData    = avsWrite & busAck & (regSel == SEL_DATA);
  assign wrDir     = avsWrite & busAck & (regSel == SEL_DIR);
  assign wrAnaEn   = avsWrite & busAck & (regSel == SEL_ANAEN);
  assign rdCapture = avsRead & ~busAck;

  // *****************************************
  // Avalon-MM slave
  // *****************************************
  // One wait state per access; write lands on the edge with waitrequest low
  assign busReq         = avsRead | avsWrite;
  assign avsWaitrequest = busReq & ~busAck;

  // Ack lasts one cycle, so a request held past completion starts afresh
  always @(posedge mclk) begin
    if (!resetn) begin
      busAck <= 1'b0;
    end else begin
      busAck <= busReq & ~busAck;
    end
  end

  reg [31:0] mergedWord;
  always @* begin
    mergedWord = 32'h0000_0000;
    case (regSel)
      SEL_DATA:  mergedWord = mergeBytes({{(32-NPIN){1'b0}}, portData}, avsWritedata, avsByteenable);
      SEL_DIR:   mergedWord = mergeBytes({{(32-NPIN){1'b0}}, portDir}, avsWritedata, avsByteenable);
      SEL_ANAEN: mergedWord = mergeBytes({{(32-NANA){1'b0}}, analogEn}, avsWritedata, avsByteenable);
      default:        mergedWord = 32'h0000_0000;
    endcase
  end

  // Port data register
  always @(posedge mclk) begin
    if (!resetn) begin
      portData <= `PPM_RST_DATA;
    end else if (wrData) begin
      portData <= mergedWord[NPIN-1:0];
    end
  end

  // Port direction register
  always @(posedge mclk) begin
    if (!resetn) begin
      portDir <= `PPM_RST_DIR;
    end else if (wrDir) begin
      portDir <= mergedWord[NPIN-1:0];
    end
  end

  // Analog enable; reset leaves every analog pin on the converter
  always @(posedge mclk) begin
    if (!resetn) begin
      analogEn <= `PPM_RST_ANAEN;
    end else if (wrAnaEn) begin
      analogEn <= mergedWord[NANA-1:0];
    end
  end

  // Read data captured in the wait cycle, stands at the completing edge
  reg [31:0] readWord;
  always @* begin
    readWord = 32'h0000_0000;
    case (regSel)
      SEL_DATA:  readWord = {{(32-NPIN){1'b0}}, portData};
      SEL_DIR:   readWord = {{(32-NPIN){1'b0}}, portDir};
      SEL_ANAEN: readWord = {{(32-NANA){1'b0}}, analogEn};
      SEL_LEVEL: readWord = {{(32-NPIN){1'b0}}, gatedLevel};
      default:   readWord = 32'h0000_0000;
    endcase
  end

  always @(posedge mclk) begin
    if (!resetn) begin
      avsReaddata <= 32'h0000_0000;
    end else if (rdCapture) begin
      avsReaddata <= readWord;
    end
  end

  // *****************************************
  // Pin input synchronisers
  // *****************************************
  // Third stage feeds both the agreement test and the accepted level; costs one cycle of latency
  assign stageAgree = ~(syncB ^ syncC);

  generate
    for (g = 0; g < NPIN; g = g + 1) begin : gSync
      always @(posedge mclk) begin
        if (!resetn) begin
          syncA[g]    <= 1'b0;
          syncB[g]    <= 1'b0;
          syncC[g]    <= 1'b0;
          pinLevel[g] <= 1'b0;
        end else begin
          syncA[g] <= padIn[g];
          syncB[g] <= syncA[g];
          syncC[g] <= syncB[g];
          // Level accepted only once second and third stages agree
          if (stageAgree[g]) begin
            pinLevel[g] <= syncC[g];
          end
        end
      end
    end
  endgenerate

  // Mask follows NANA, so a narrower converter leaves the upper pins digital
  generate
    for (g = 0; g < NPIN; g = g + 1) begin : gAnaMask
      if ((g >= `PPM_BIT_ANA0) && (g < `PPM_BIT_ANA0 + NANA)) begin : gAna
        assign analogMask[g] = analogEn[g - `PPM_BIT_ANA0];
      end else begin : gDig
        assign analogMask[g] = 1'b0;
      end
    end
  endgenerate

  // Digital input buffer gated off on analog pins
  always @(posedge mclk) begin
    if (!resetn) begin
      gatedLevel <= {NPIN{1'b0}};
    end else begin
      gatedLevel <= pinLevel & ~analogMask;
    end
  end

  // *****************************************
  // Peripheral input connections
  // *****************************************
  // Pin levels always reach the peripherals, whatever the direction bits
  // Clock pins read the pad even while driving it, for both-way clocks
  assign asyncClkIn  = gatedLevel[`PPM_BIT_ACLK];
  assign syncClkIn   = gatedLevel[`PPM_BIT_SCLK];
  assign syncRxData  = gatedLevel[`PPM_BIT_SRX];
  assign extIrqUpper = gatedLevel[`PPM_BIT_IRQ0 +: 4];
  assign convTrigger = gatedLevel[`PPM_BIT_TRIG];
  assign timerEvent  = gatedLevel[`PPM_BIT_TEVT];
  assign analogChannelEn = analogEn;

  // *****************************************
  // Output multiplexer
  // *****************************************
  // Only the four output-capable pins can be claimed by a peripheral
  wire [NPIN-1:0]  periphEn;
  wire [NPIN-1:0]  periphVal;

  assign periphEn  = placeBit(asyncClkOutEn, `PPM_BIT_ACLK)
                   | placeBit(asyncTxOutEn, `PPM_BIT_ATX)
                   | placeBit(syncTxOutEn, `PPM_BIT_STX)
                   | placeBit(syncClkOutEn, `PPM_BIT_SCLK);
  assign periphVal = placeBit(asyncClkOut, `PPM_BIT_ACLK)
                   | placeBit(asyncTxData, `PPM_BIT_ATX)
                   | placeBit(syncTxData, `PPM_BIT_STX)
                   | placeBit(syncClkOut, `PPM_BIT_SCLK);

  // Analog use beats a peripheral claim, which beats the port registers
  generate
    for (g = 0; g < NPIN; g = g + 1) begin : gPad
      assign next_padOe[g]  = ~analogMask[g] & (periphEn[g] | portDir[g]);
      assign next_padOut[g] = ~analogMask[g] & (periphEn[g] ? periphVal[g] : portData[g]);
    end
  endgenerate

  // Registered pads: one cycle from any enable change to the pin
  always @(posedge mclk) begin
    if (!resetn) begin
      padOut <= {NPIN{1'b0}};
      padOe  <= {NPIN{1'b0}};
    end else begin
      padOut <= next_padOut;
      padOe  <= next_padOe;
    end
  end

endmodule // ppm_port_pin_function_mux

// file: sim/ppm_mux_props.sv
// Port checker for the pin mux.
// Assumes one mclk domain, synchronous active-low reset.
`timescale 1ns/100ps
module ppm_mux_props #(
  parameter NPIN = 19,
  parameter NANA = 8
) (
  input wire            mclk,
  input wire            resetn,
  input wire            avsRead,
  input wire            avsWrite,
  input wire            avsWaitrequest,
  input wire [NPIN-1:0] padIn,
  input wire [NPIN-1:0] padOut,
  input wire [NPIN-1:0] padOe,
  input wire            asyncClkOutEn,
  input wire            asyncClkOut,
  input wire            asyncTxOutEn,
  input wire            asyncTxData,
  input wire            syncTxOutEn,
  input wire            syncTxData,
  input wire            syncClkOutEn,
  input wire            syncClkOut,
  input wire            syncRxData,
  input wire            timerEvent,
  input wire [NANA-1:0] analogChannelEn
);
  // ****
  // Properties
  // ****
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  AST_ACLK: assert property ($past(asyncClkOutEn) |-> padOe[0] && padOut[0] == $past(asyncClkOut))
    else $error("async clock pin");
  AST_ATX: assert property ($past(asyncTxOutEn) |-> padOe[1] && padOut[1] == $past(asyncTxData))
    else $error("async tx pin");
  AST_STX: assert property ($past(syncTxOutEn) |-> padOe[2] && padOut[2] == $past(syncTxData))
    else $error("sync tx pin");
  AST_SCLK: assert property ($past(syncClkOutEn) |-> padOe[3] && padOut[3] == $past(syncClkOut))
    else $error("sync clock pin");
  AST_ANA: assert property ((padOe[18:11] & $past(analogChannelEn)) == 8'h00)
    else $error("analog pin driven");
  AST_WAIT: assert property ((avsRead || avsWrite) && !$past(avsRead) && !$past(avsWrite)
    |-> avsWaitrequest ##1 !avsWaitrequest) else $error("wait state count");
  AST_SRX: assert property ($past(padIn[4], 4) == $past(padIn[4], 6) && $past(padIn[4], 5) == $past(padIn[4], 6)
    |-> syncRxData == $past(padIn[4], 5)) else $error("sync rx level");
  AST_TEVT: assert property ($past(padIn[10], 4) == $past(padIn[10], 6) && $past(padIn[10], 5) == $past(padIn[10], 6)
    |-> timerEvent == $past(padIn[10], 5)) else $error("timer event level");
endmodule // ppm_mux_props
bind ppm_port_pin_function_mux ppm_mux_props #(.NPIN(NPIN), .NANA(NANA)) u_props (
  .mclk(mclk), .resetn(resetn), .avsRead(avsRead), .avsWrite(avsWrite), .avsWaitrequest(avsWaitrequest),
  .padIn(padIn), .padOut(padOut), .padOe(padOe), .asyncClkOutEn(asyncClkOutEn), .asyncClkOut(asyncClkOut),
  .asyncTxOutEn(asyncTxOutEn), .asyncTxData(asyncTxData), .syncTxOutEn(syncTxOutEn), .syncTxData(syncTxData),
  .syncClkOutEn(syncClkOutEn), .syncClkOut(syncClkOut), .syncRxData(syncRxData), .timerEvent(timerEvent),
  .analogChannelEn(analogChannelEn));

// file: sim/ppm_pad_board.sv
// Board model for the shared pads.
// Assumes pad value and enable from the mux.
`timescale 1ns/100ps
module ppm_pad_board (
  input  wire [18:0] padOut,
  input  wire [18:0] padOe,
  input  wire [18:0] extEn,
  input  wire [18:0] extVal,
  output wire [18:0] padIn
);
  // Undriven pads fall to a pull-down
  assign padIn = (padOe & padOut) | (~padOe & extEn & extVal);
endmodule // ppm_pad_board

// file: sim/ppm_port_pin_function_mux_bench.sv
// Bench for the pin mux: bus tasks, pin and register checks.
// Assumes the board pad model and the bound checker.
`timescale 1ns/100ps
module ppm_port_pin_function_mux_bench;
  reg         mclk = 0;
  reg         resetn = 0;
  reg  [3:0]  adr = 0;
  reg         rd = 0;
  reg         wr = 0;
  reg  [31:0] wd = 0;
  reg  [31:0] q;
  reg  [7:0]  pe = 0;
  reg  [7:0]  m;
  reg  [18:0] xEn = 0;
  reg  [18:0] xVal = 0;
  reg  [18:0] v;
  wire [18:0] pIn;
  wire [18:0] pOut;
  wire [18:0] pOe;
  wire [31:0] rdat;
  wire [3:0]  irq;
  wire [7:0]  ana;
  wire        wrq, aCi, sCi, sRx, trg, tev;
  integer     fails = 0;
  integer     n_tests = 0;
  integer     k;
  ppm_port_pin_function_mux uut (
    .mclk(mclk), .resetn(resetn), .avsAddress(adr), .avsRead(rd), .avsWrite(wr), .avsWritedata(wd),
    .avsByteenable(4'hF), .avsReaddata(rdat), .avsWaitrequest(wrq), .padIn(pIn), .padOut(pOut), .padOe(pOe),
    .asyncClkOutEn(pe[7]), .asyncClkOut(pe[6]), .asyncClkIn(aCi), .asyncTxOutEn(pe[5]), .asyncTxData(pe[4]),
    .syncTxOutEn(pe[3]), .syncTxData(pe[2]), .syncClkOutEn(pe[1]), .syncClkOut(pe[0]), .syncClkIn(sCi),
    .syncRxData(sRx), .extIrqUpper(irq), .convTrigger(trg), .timerEvent(tev), .analogChannelEn(ana));
  ppm_pad_board board (.padOut(pOut), .padOe(pOe), .extEn(xEn), .extVal(xVal), .padIn(pIn));
  always #4 mclk = ~mclk;
  // ****
  // Tasks
  // ****
  task chk(input [31:0] e, input [31:0] g, input [8*5:1] nm);
    begin
      n_tests = n_tests + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("BAD %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  // Holds the request until waitrequest is seen low at a rising edge
  task bus(input w, input [3:0] a, input [31:0] d);
    begin
      @(posedge mclk);
      rd <= !w;
      wr <= w;
      adr <= a;
      wd <= d;
      @(posedge mclk);
      while (wrq !== 1'b0)
        @(posedge mclk);
      q = rdat;
      rd <= 0;
      wr <= 0;
    end
  endtask
  task wt(input integer n);
    repeat (n) @(negedge mclk);
  endtask
  task finish_test;
    begin
      $display("Checks %0d, mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  // ****
  // Tests
  // ****
  initial begin
    repeat (12) @(posedge mclk);
    resetn <= 1;
    bus(0, 4'h8, 0);
    chk(8'hFF, q, "anaen");
    chk(0, pOe, "oe");
    bus(1, 4'h4, 32'h7FFFF);
    bus(1, 4'h0, 32'h55555);
    wt(8);
    chk(32'h7FF, pOe, "oe");
    chk(32'h555, pOut[10:0], "out");
    chk(32'h169, {aCi, sCi, sRx, irq, trg, tev}, "in");
    bus(0, 4'h0, 0);
    chk(32'h55555, q, "data");
    @(posedge mclk);
    pe <= 8'hBB;
    wt(2);
    chk(32'hA, pOut[3:0], "per");
    @(posedge mclk);
    pe <= 8'h11;
    wt(2);
    chk(32'h5, pOut[3:0], "port");
    bus(1, 4'h4, 0);
    for (k = 0; k < 2; k = k + 1) begin
      v = k ? 19'h2AAAA : 19'h7FFFF;
      @(posedge mclk);
      xEn <= 19'h7FFFF;
      xVal <= v;
      wt(8);
      chk({v[0], v[3], v[4], v[8:5], v[9], v[10]}, {aCi, sCi, sRx, irq, trg, tev}, "pin");
      bus(0, 4'hC, 0);
      chk(v[10:0], q, "lvl");
    end
    bus(1, 4'h4, 32'h7F800);
    for (k = 0; k < 2; k = k + 1) begin
      m = k ? 8'h0F : 8'hF0;
      bus(1, 4'h8, m);
      wt(8);
      chk(m, ana, "ana");
      chk(m ^ 8'hFF, pOe[18:11], "aoe");
      chk(8'hAA & ~m, pOut[18:11] & ~m, "aout");
      bus(0, 4'hC, 0);
      chk(8'hAA & ~m, q[18:11], "alvl");
    end
    bus(1, 4'h2, 32'hFFFF);
    bus(0, 4'h2, 0);
    chk(0, q, "unmap");
    bus(0, 4'h0, 0);
    chk(32'h55555, q, "data");
    finish_test;
  end
  initial begin
    #20000;
    fails = fails + 1;
    finish_test;
  end
endmodule // ppm_port_pin_function_mux_bench
